// ### core/bcm_pkg.sv
// Shared constants, types and register map for the backlash compensation monitor.
package bcm_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int POS_W = 64;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SEL_W = 16;
  localparam int CODE_W = 4;
  localparam int SLOTS = 4;

  // ****************************************************************
  // Register byte addresses and fields
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_OFFSET_REF = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_OFFSET_PULSE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_OPT1_SEL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_OPT2_SEL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MON_SEL = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_MON_VAL = 8'h20;
  localparam logic [ADDR_W-1:0] MON_VAL_STRIDE = 8'h04;
  localparam int CTRL_DIR_BIT = 0;
  localparam int STATUS_COMP_BIT = 0;
  localparam int STATUS_SERVO_BIT = 1;
  localparam int STATUS_INHIBIT_BIT = 2;
  localparam int STATUS_MODE_LSB = 3;

  // ****************************************************************
  // Reset values and encodings
  // ****************************************************************
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [SEL_W-1:0] RST_SEL = 16'h0000;
  localparam logic [POS_W-1:0] POS_ZERO = 64'h0000_0000_0000_0000;
  localparam logic DIR_FORWARD = 1'b0;
  localparam logic DIR_REVERSE = 1'b1;

  localparam logic [CODE_W-1:0] MON_FILT_REF = 4'h0;
  localparam logic [CODE_W-1:0] MON_PLAIN_REF = 4'h1;
  localparam logic [CODE_W-1:0] MON_POS_ERR = 4'h2;
  localparam logic [CODE_W-1:0] MON_MACH_FB = 4'h3;
  localparam logic [CODE_W-1:0] MON_LATCH_FB = 4'h4;
  localparam logic [CODE_W-1:0] MON_UNFILT_REF = 4'h5;
  localparam logic [CODE_W-1:0] MON_TARGET = 4'h6;
  localparam logic [CODE_W-1:0] MON_OPT_ONE = 4'he;
  localparam logic [CODE_W-1:0] MON_OPT_TWO = 4'hf;

  localparam logic [SEL_W-1:0] OPT_ERR_LO = 16'h0003;
  localparam logic [SEL_W-1:0] OPT_ERR_HI = 16'h0004;
  localparam logic [SEL_W-1:0] OPT_ENC_LO = 16'h000a;
  localparam logic [SEL_W-1:0] OPT_ENC_HI = 16'h000b;
  localparam logic [SEL_W-1:0] OPT_EXT_LO = 16'h000c;
  localparam logic [SEL_W-1:0] OPT_EXT_HI = 16'h000d;
  localparam logic [SEL_W-1:0] OPT_IN_SPEED = 16'h0017;
  localparam logic [SEL_W-1:0] OPT_ERR_AMOUNT = 16'h0018;
  localparam logic [SEL_W-1:0] OPT_IN_COUNTER = 16'h001c;
  localparam logic [SEL_W-1:0] OPT_FB_COUNTER = 16'h001d;
  localparam logic [SEL_W-1:0] OPT_CLOSED_COUNTER = 16'h001e;
  localparam logic [SEL_W-1:0] OPT_PREV_LATCH = 16'h0080;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_POSITION = 3'b001,
    MODE_SPEED = 3'b010,
    MODE_TORQUE = 3'b100
  } bcm_mode_t;

  typedef enum logic [1:0] {
    COMP_OFF = 2'b01,
    COMP_ON = 2'b10
  } bcm_comp_state_t;

  typedef struct packed {
    logic servoOn;
    logic overtravel;
    logic softLimit;
    bcm_mode_t mode;
    logic cmdValid;
    logic [DATA_W-1:0] refStep;
    logic [POS_W-1:0] filteredRef;
    logic [POS_W-1:0] targetPos;
    logic [POS_W-1:0] shaftRef;
    logic [POS_W-1:0] shaftPulses;
    logic [POS_W-1:0] extCount;
    logic [POS_W-1:0] extRef;
    logic latchStrobe;
  } bcm_drive_t;

  typedef struct packed {
    logic [POS_W-1:0] filtRef;
    logic [POS_W-1:0] plainRef;
    logic [POS_W-1:0] posErr;
    logic [POS_W-1:0] machFb;
    logic [POS_W-1:0] latchFb;
    logic [POS_W-1:0] unfiltRef;
    logic [POS_W-1:0] target;
    logic [POS_W-1:0] encRef;
    logic [POS_W-1:0] extRef;
    logic [POS_W-1:0] prevLatchPulse;
    logic [DATA_W-1:0] inSpeed;
    logic [DATA_W-1:0] inCounter;
    logic [DATA_W-1:0] fbCounter;
    logic [DATA_W-1:0] closedCounter;
  } bcm_mon_t;

endpackage : bcm_pkg

// ### core/bcm_comp_gate.sv
// Decides whether the backlash offset is applied to the driven reference.
`timescale 1ns/100ps
module bcm_comp_gate (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Drive conditions
  input wire logic servoOn,
  input wire logic inhibit,
  input wire bcm_pkg::bcm_mode_t mode,
  input wire logic cmdValid,
  input wire logic [bcm_pkg::DATA_W-1:0] refStep,
  input wire logic dirSel,
  // Decision
  output logic compActive
);
  import bcm_pkg::*;

  typedef struct packed {
    bcm_comp_state_t state;
  } bcm_gate_state_t;

  bcm_gate_state_t cur;
  bcm_gate_state_t next_cur;
  logic allowed;
  logic moving;
  logic inDir;

  assign allowed = servoOn && !inhibit && (mode == MODE_POSITION);
  assign moving = cmdValid && (refStep != RST_WORD);
  assign inDir = (dirSel == DIR_REVERSE) ? refStep[DATA_W-1] : !refStep[DATA_W-1];

  always_comb
  begin
    next_cur = cur;
    unique case (cur.state)
      COMP_OFF:
      begin
        if (allowed && moving && inDir)
        begin
          next_cur.state = COMP_ON;
        end
      end
      COMP_ON:
      begin
        if (!allowed)
        begin
          next_cur.state = COMP_OFF;
        end
        else if (moving && !inDir)
        begin
          next_cur.state = COMP_OFF;
        end
      end
      default:
      begin
        next_cur.state = COMP_OFF;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur.state <= COMP_OFF;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign compActive = (cur.state == COMP_ON);

  a_gate_opposite: assert property (@(posedge clock) disable iff (!rst_n)
    allowed && moving && !inDir |=> !compActive)
    else $error("offset kept after opposite move");

endmodule : bcm_comp_gate

// ### core/bcm_mon_mux.sv
// Selects one monitor slot value from a monitor code and the option selections.
`timescale 1ns/100ps
module bcm_mon_mux (
  // Selection
  input wire logic [bcm_pkg::CODE_W-1:0] code,
  input wire logic [bcm_pkg::SEL_W-1:0] opt1Sel,
  input wire logic [bcm_pkg::SEL_W-1:0] opt2Sel,
  // Monitor sources
  input wire bcm_pkg::bcm_mon_t mon,
  // Result
  output logic [bcm_pkg::DATA_W-1:0] value
);
  import bcm_pkg::*;

  function automatic logic [DATA_W-1:0] optItem(input logic [SEL_W-1:0] sel,
                                                input bcm_mon_t m);
    logic [DATA_W-1:0] r;
    r = RST_WORD;
    unique case (sel)
      OPT_ERR_LO: r = m.posErr[DATA_W-1:0];
      OPT_ERR_HI: r = m.posErr[POS_W-1:DATA_W];
      OPT_ENC_LO: r = m.encRef[DATA_W-1:0];
      OPT_ENC_HI: r = m.encRef[POS_W-1:DATA_W];
      OPT_EXT_LO: r = m.extRef[DATA_W-1:0];
      OPT_EXT_HI: r = m.extRef[POS_W-1:DATA_W];
      OPT_IN_SPEED: r = m.inSpeed;
      OPT_ERR_AMOUNT: r = m.posErr[DATA_W-1:0];
      OPT_IN_COUNTER: r = m.inCounter;
      OPT_FB_COUNTER: r = m.fbCounter;
      OPT_CLOSED_COUNTER: r = m.closedCounter;
      OPT_PREV_LATCH: r = m.prevLatchPulse[DATA_W-1:0];
      default: r = RST_WORD;
    endcase
    return r;
  endfunction : optItem

  always_comb
  begin
    value = RST_WORD;
    unique case (code)
      MON_FILT_REF: value = mon.filtRef[DATA_W-1:0];
      MON_PLAIN_REF: value = mon.plainRef[DATA_W-1:0];
      MON_POS_ERR: value = mon.posErr[DATA_W-1:0];
      MON_MACH_FB: value = mon.machFb[DATA_W-1:0];
      MON_LATCH_FB: value = mon.latchFb[DATA_W-1:0];
      MON_UNFILT_REF: value = mon.unfiltRef[DATA_W-1:0];
      MON_TARGET: value = mon.target[DATA_W-1:0];
      MON_OPT_ONE: value = optItem(opt1Sel, mon);
      MON_OPT_TWO: value = optItem(opt2Sel, mon);
      default: value = RST_WORD;
    endcase
  end

endmodule : bcm_mon_mux

// ### core/bcm_top.sv
// Backlash compensation gating, position bookkeeping and monitor register file.
`timescale 1ns/100ps
module bcm_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [bcm_pkg::ADDR_W-1:0] addr,
  input wire logic [bcm_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [bcm_pkg::DATA_W-1:0] rdata,
  // Drive side
  input wire bcm_pkg::bcm_drive_t drive,
  output logic [bcm_pkg::POS_W-1:0] drivenRef,
  output logic compActive
);
  import bcm_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [POS_W-1:0] plainRef;
    logic [POS_W-1:0] drivenRef;
    logic [POS_W-1:0] latchFb;
    logic [POS_W-1:0] latchPulse;
    logic [POS_W-1:0] prevLatchPulse;
    logic [DATA_W-1:0] inCounter;
    logic [DATA_W-1:0] inSpeed;
    logic [DATA_W-1:0] offsetRef;
    logic [DATA_W-1:0] offsetPulse;
    logic [SEL_W-1:0] opt1Sel;
    logic [SEL_W-1:0] opt2Sel;
    logic [SEL_W-1:0] monSel;
    logic [DATA_W-1:0] rdata;
    logic dirSel;
    logic wasServoOn;
  } bcm_top_state_t;

  bcm_top_state_t cur;
  bcm_top_state_t next_cur;
  logic inhibit;
  logic servoOffEdge;
  logic [POS_W-1:0] offRef64;
  logic [POS_W-1:0] offPulse64;
  logic [POS_W-1:0] compOff;
  logic [POS_W-1:0] compOffPulse;
  logic [POS_W-1:0] step64;
  logic [POS_W-1:0] machFb;
  logic [POS_W-1:0] posErr;
  bcm_mon_t mon;
  logic [DATA_W-1:0] slotVal [SLOTS];
  logic [DATA_W-1:0] readWord;

  function automatic logic [POS_W-1:0] signExt(input logic [DATA_W-1:0] v);
    return {{(POS_W-DATA_W){v[DATA_W-1]}}, v};
  endfunction : signExt

  // ****************************************************************
  // Compensation decision
  // ****************************************************************
  assign inhibit = drive.overtravel || drive.softLimit;

  bcm_comp_gate uGate (
    .clock(clock),
    .rst_n(rst_n),
    .servoOn(drive.servoOn),
    .inhibit(inhibit),
    .mode(drive.mode),
    .cmdValid(drive.cmdValid),
    .refStep(drive.refStep),
    .dirSel(cur.dirSel),
    .compActive(compActive)
  );

  // ****************************************************************
  // Position bookkeeping
  // ****************************************************************
  assign offRef64 = signExt(cur.offsetRef);
  assign offPulse64 = signExt(cur.offsetPulse);
  assign step64 = signExt(drive.refStep);
  // With compensation off the offset term is zero, so the feedback is the raw shaft.
  assign compOff = compActive ? offRef64 : POS_ZERO;
  assign compOffPulse = compActive ? offPulse64 : POS_ZERO;
  assign machFb = drive.shaftRef - compOff;
  assign posErr = cur.drivenRef - drive.shaftRef;
  assign servoOffEdge = cur.wasServoOn && !drive.servoOn;

  // ****************************************************************
  // Monitor sources
  // ****************************************************************
  always_comb
  begin
    mon.filtRef = drive.filteredRef;
    mon.plainRef = cur.plainRef;
    mon.posErr = posErr;
    mon.machFb = machFb;
    mon.latchFb = cur.latchFb;
    mon.unfiltRef = cur.plainRef;
    mon.target = drive.targetPos;
    mon.encRef = drive.shaftRef;
    mon.extRef = drive.extRef;
    mon.prevLatchPulse = cur.prevLatchPulse;
    mon.inSpeed = cur.inSpeed;
    mon.inCounter = cur.inCounter;
    mon.fbCounter = drive.shaftPulses[DATA_W-1:0];
    mon.closedCounter = drive.extCount[DATA_W-1:0];
  end

  genvar gi;
  generate
    for (gi = 0; gi < SLOTS; gi++)
    begin : gSlot
      bcm_mon_mux uMux (
        .code(cur.monSel[gi*CODE_W +: CODE_W]),
        .opt1Sel(cur.opt1Sel),
        .opt2Sel(cur.opt2Sel),
        .mon(mon),
        .value(slotVal[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Read decode
  // ****************************************************************
  always_comb
  begin
    readWord = RST_WORD;
    if (addr == OFF_CTRL)
    begin
      readWord[CTRL_DIR_BIT] = cur.dirSel;
    end
    else if (addr == OFF_OFFSET_REF)
    begin
      readWord = cur.offsetRef;
    end
    else if (addr == OFF_OFFSET_PULSE)
    begin
      readWord = cur.offsetPulse;
    end
    else if (addr == OFF_OPT1_SEL)
    begin
      readWord[SEL_W-1:0] = cur.opt1Sel;
    end
    else if (addr == OFF_OPT2_SEL)
    begin
      readWord[SEL_W-1:0] = cur.opt2Sel;
    end
    else if (addr == OFF_MON_SEL)
    begin
      readWord[SEL_W-1:0] = cur.monSel;
    end
    else if (addr == OFF_STATUS)
    begin
      readWord[STATUS_COMP_BIT] = compActive;
      readWord[STATUS_SERVO_BIT] = drive.servoOn;
      readWord[STATUS_INHIBIT_BIT] = inhibit;
      readWord[STATUS_MODE_LSB +: 3] = drive.mode;
    end
    else
    begin
      for (int i = 0; i < SLOTS; i++)
      begin
        if (addr == OFF_MON_VAL + MON_VAL_STRIDE * i[ADDR_W-1:0])
        begin
          readWord = slotVal[i];
        end
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_cur = cur;
    next_cur.wasServoOn = drive.servoOn;
    // Read data stand for one cycle only, zero otherwise.
    next_cur.rdata = rd ? readWord : RST_WORD;
    if (wr)
    begin
      if (addr == OFF_CTRL)
      begin
        next_cur.dirSel = wdata[CTRL_DIR_BIT];
      end
      else if (addr == OFF_OFFSET_REF)
      begin
        next_cur.offsetRef = wdata;
      end
      else if (addr == OFF_OFFSET_PULSE)
      begin
        next_cur.offsetPulse = wdata;
      end
      else if (addr == OFF_OPT1_SEL)
      begin
        next_cur.opt1Sel = wdata[SEL_W-1:0];
      end
      else if (addr == OFF_OPT2_SEL)
      begin
        next_cur.opt2Sel = wdata[SEL_W-1:0];
      end
      else if (addr == OFF_MON_SEL)
      begin
        next_cur.monSel = wdata[SEL_W-1:0];
      end
    end
    // The jump at servo off keeps the reference on the shaft, which still holds the offset.
    if (servoOffEdge && compActive)
    begin
      next_cur.plainRef = cur.plainRef + offRef64;
    end
    else if (!drive.servoOn || inhibit)
    begin
      next_cur.plainRef = drive.shaftRef;
    end
    else if (drive.cmdValid)
    begin
      next_cur.plainRef = cur.plainRef + step64;
    end
    if (drive.cmdValid)
    begin
      next_cur.inCounter = cur.inCounter + drive.refStep;
      next_cur.inSpeed = drive.refStep;
    end
    next_cur.drivenRef = cur.plainRef + compOff;
    if (drive.latchStrobe)
    begin
      next_cur.latchFb = machFb;
      next_cur.latchPulse = drive.shaftPulses - compOffPulse;
      next_cur.prevLatchPulse = cur.latchPulse;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur.plainRef <= POS_ZERO;
      cur.drivenRef <= POS_ZERO;
      cur.latchFb <= POS_ZERO;
      cur.latchPulse <= POS_ZERO;
      cur.prevLatchPulse <= POS_ZERO;
      cur.inCounter <= RST_WORD;
      cur.inSpeed <= RST_WORD;
      cur.offsetRef <= RST_WORD;
      cur.offsetPulse <= RST_WORD;
      cur.opt1Sel <= RST_SEL;
      cur.opt2Sel <= RST_SEL;
      cur.monSel <= RST_SEL;
      cur.rdata <= RST_WORD;
      cur.dirSel <= DIR_FORWARD;
      cur.wasServoOn <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign rdata = cur.rdata;
  assign drivenRef = cur.drivenRef;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence sOffTwice;
    !drive.servoOn [*2];
  endsequence

  sequence sDirWriteRead;
    (wr && addr == OFF_CTRL) ##1 (rd && addr == OFF_CTRL);
  endsequence

  a_servo_off_nocomp: assert property (!drive.servoOn |=> !compActive)
    else $error("offset applied with servo off");

  a_inhibit_nocomp: assert property (inhibit |=> !compActive)
    else $error("offset applied during overtravel");

  a_mode_nocomp: assert property (drive.mode != MODE_POSITION |=> !compActive)
    else $error("offset applied outside position control");

  a_leave_pos_clear: assert property (
    compActive && drive.mode != MODE_POSITION |=> !compActive)
    else $error("offset kept after leaving position control");

  a_comp_dir_set: assert property (
    drive.servoOn && !inhibit && drive.mode == MODE_POSITION
    && drive.cmdValid && drive.refStep != RST_WORD
    && (drive.refStep[DATA_W-1] == cur.dirSel) |=> compActive)
    else $error("offset missing after move in chosen direction");

  a_off_shift: assert property (servoOffEdge && compActive
    |=> cur.plainRef == $past(cur.plainRef) + $past(offRef64))
    else $error("reference not shifted by offset at servo off");

  a_off_identical: assert property (sOffTwice
    |-> machFb == drive.shaftRef && cur.plainRef == $past(drive.shaftRef))
    else $error("feedback and reference differ with servo off");

  // The offset that built the driven reference is the one of the previous cycle.
  a_err_comp_ref: assert property (compActive ##1 compActive
    |-> posErr == $past(cur.plainRef) + $past(offRef64) - drive.shaftRef)
    else $error("error not against compensated reference");

  a_counter_raw: assert property (drive.cmdValid
    |=> cur.inCounter == $past(cur.inCounter) + $past(drive.refStep))
    else $error("input counter wrong");

  a_latch_sub: assert property (drive.latchStrobe
    |=> cur.latchFb == $past(drive.shaftRef) - $past(compOff))
    else $error("latched feedback keeps offset");

  a_read_once: assert property (!rd |=> rdata == RST_WORD)
    else $error("read data outside read answer");

  a_dir_readback: assert property (sDirWriteRead
    |=> rdata[CTRL_DIR_BIT] == $past(wdata[CTRL_DIR_BIT], 2))
    else $error("direction select readback wrong");

endmodule : bcm_top

// ### verification/bcm_motor_model.sv
// Behavioural motor and encoders that follow the driven reference.
`timescale 1ns/100ps
module bcm_motor_model
  import bcm_pkg::*;
#(
  parameter logic [POS_W-1:0] EXT_START = 64'h0000_0001_2345_6789
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Driven reference from the block
  input wire logic [POS_W-1:0] drivenRef,
  // Measured motion
  output logic [POS_W-1:0] shaftRef,
  output logic [POS_W-1:0] extCount
);
  // ****************************************************************
  // Shaft follows one tick later
  // ****************************************************************
  // An ideal stiff axis: the shaft lands on the reference a tick later.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shaftRef <= POS_ZERO;
    end
    else
    begin
      shaftRef <= drivenRef;
    end
  end
  assign extCount = EXT_START + shaftRef;
endmodule : bcm_motor_model

// ### verification/backlash_compensation_monitor_test.sv
// Self-checking bench for the backlash compensation monitor.
`timescale 1ns/100ps
module backlash_compensation_monitor_test;
  import bcm_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  bcm_drive_t cmd = '0;
  bcm_drive_t drive;
  logic [POS_W-1:0] drivenRef;
  logic compActive;
  logic [POS_W-1:0] shaft;
  logic [POS_W-1:0] ext;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  logic [DATA_W-1:0] got;

  always #10 clock = ~clock;

  always_comb
  begin
    drive = cmd;
    drive.shaftRef = shaft;
    drive.shaftPulses = shaft;
    drive.extCount = ext;
    drive.extRef = ext;
  end

  bcm_top u_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .drive(drive), .drivenRef(drivenRef), .compActive(compActive));
  bcm_motor_model u_motor (.clock(clock), .rst_n(rst_n), .drivenRef(drivenRef),
    .shaftRef(shaft), .extCount(ext));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : read_reg

  // Write and read back to back, with no idle cycle between the strobes.
  task automatic write_then_read(input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask : write_then_read

  // Slot 0 shows option one and slot 1 option two.
  task automatic opt_pair(input logic [15:0] s1, input logic [15:0] s2, input logic [31:0] e1,
    input logic [31:0] e2);
    write_reg(OFF_OPT1_SEL, {16'h0, s1});
    write_reg(OFF_OPT2_SEL, {16'h0, s2});
    read_reg(OFF_MON_VAL, got);
    check("optionOne", {32'h0, got}, {32'h0, e1});
    read_reg(OFF_MON_VAL + 8'h04, got);
    check("optionTwo", {32'h0, got}, {32'h0, e2});
  endtask : opt_pair

  // One command step, then a settling pause before the gate is judged.
  task automatic step(input logic [31:0] s, input logic exp);
    @(posedge clock);
    cmd.refStep <= s;
    cmd.cmdValid <= 1'b1;
    @(posedge clock);
    cmd.cmdValid <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check("compActive", {63'h0, compActive}, {63'h0, exp});
  endtask : step

  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic after_reset();
    check("compActive", {63'h0, compActive}, 64'h0);
    check("drivenRef", drivenRef, 64'h0);
    read_reg(OFF_CTRL, got);
    check("ctrl", {32'h0, got}, 64'h0);
    read_reg(8'h3c, got);
    check("unmapped", {32'h0, got}, 64'h0);
  endtask : after_reset

  task automatic directional();
    write_reg(OFF_OFFSET_REF, 32'h0000_0007);
    write_reg(OFF_OFFSET_PULSE, 32'h0000_0007);
    write_reg(OFF_MON_SEL, 32'h0000_2e13);
    write_reg(OFF_OPT1_SEL, {16'h0, OPT_CLOSED_COUNTER});
    @(posedge clock);
    cmd.servoOn <= 1'b1;
    cmd.mode <= MODE_POSITION;
    step(32'h0000_0005, 1'b1);
    check("drivenRef", drivenRef, 64'hc);
    read_reg(OFF_MON_VAL + 8'h04, got);
    check("plainRef", {32'h0, got}, 64'h5);
    read_reg(OFF_MON_VAL, got);
    check("machFb", {32'h0, got}, 64'h5);
    read_reg(OFF_MON_VAL + 8'h08, got);
    check("closedCounter", {32'h0, got}, 64'h2345_6795);
    step(32'hffff_fffd, 1'b0);
    check("drivenRef", drivenRef, 64'h2);
    step(32'h0000_0001, 1'b1);
  endtask : directional

  task automatic servo_off();
    @(posedge clock);
    cmd.servoOn <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check("compActive", {63'h0, compActive}, 64'h0);
    read_reg(OFF_MON_VAL + 8'h04, got);
    check("plainRef", {32'h0, got}, 64'ha);
    read_reg(OFF_MON_VAL, got);
    check("machFb", {32'h0, got}, 64'ha);
  endtask : servo_off

  task automatic inhibit_and_modes();
    @(posedge clock);
    cmd.servoOn <= 1'b1;
    cmd.overtravel <= 1'b1;
    step(32'h0000_0001, 1'b0);
    @(posedge clock);
    cmd.overtravel <= 1'b0;
    cmd.softLimit <= 1'b1;
    step(32'h0000_0001, 1'b0);
    @(posedge clock);
    cmd.softLimit <= 1'b0;
    step(32'h0000_0001, 1'b1);
    @(posedge clock);
    cmd.mode <= MODE_SPEED;
    step(32'h0000_0001, 1'b0);
    check("drivenRef", drivenRef, 64'hc);
    @(posedge clock);
    cmd.mode <= MODE_TORQUE;
    step(32'h0000_0001, 1'b0);
    @(posedge clock);
    cmd.mode <= MODE_POSITION;
    step(32'h0000_0001, 1'b1);
    check("drivenRef", drivenRef, 64'h15);
  endtask : inhibit_and_modes

  // Compensation is on here: reference 14, shaft 21, nine steps counted, last step 1.
  task automatic monitors();
    @(posedge clock);
    cmd.filteredRef <= 64'h0000_0003_1111_2222;
    cmd.targetPos <= 64'h0000_0004_3333_4444;
    cmd.latchStrobe <= 1'b1;
    repeat (2) @(posedge clock);
    cmd.latchStrobe <= 1'b0;
    write_reg(OFF_MON_SEL, 32'h0000_6540);
    read_reg(OFF_MON_VAL, got);
    check("filtRef", {32'h0, got}, 64'h1111_2222);
    read_reg(OFF_MON_VAL + 8'h04, got);
    check("latchFb", {32'h0, got}, 64'he);
    read_reg(OFF_MON_VAL + 8'h08, got);
    check("unfiltRef", {32'h0, got}, 64'he);
    read_reg(OFF_MON_VAL + 8'h0c, got);
    check("target", {32'h0, got}, 64'h3333_4444);
    write_reg(OFF_MON_SEL, 32'h0000_00fe);
    opt_pair(OPT_ERR_LO, OPT_ERR_HI, 32'h0, 32'h0);
    opt_pair(OPT_ENC_LO, OPT_ENC_HI, 32'h15, 32'h0);
    opt_pair(OPT_EXT_LO, OPT_EXT_HI, 32'h2345_679e, 32'h1);
    opt_pair(OPT_IN_SPEED, OPT_ERR_AMOUNT, 32'h1, 32'h0);
    opt_pair(OPT_IN_COUNTER, OPT_FB_COUNTER, 32'h9, 32'h15);
    opt_pair(OPT_PREV_LATCH, 16'h0001, 32'he, 32'h0);
    read_reg(OFF_STATUS, got);
    check("status", {32'h0, got}, 64'hb);
    write_then_read(OFF_CTRL, 32'h0000_0001, got);
    check("ctrl", {32'h0, got}, 64'h1);
    step(32'h0000_0001, 1'b0);
    step(32'hffff_ffff, 1'b1);
  endtask : monitors

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    cmd.mode = MODE_SPEED;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    after_reset();
    directional();
    servo_off();
    inhibit_and_modes();
    monitors();
    tally_and_finish();
  end
endmodule : backlash_compensation_monitor_test
